// ---- srawd_params.svh ----
`ifndef SRAWD_PARAMS_SVH
`define SRAWD_PARAMS_SVH

// Datapath width
`define SRAWD_W            32
`define SRAWD_CNT_W        5

// Register byte offsets
`define SRAWD_OFS_SRC      8'h00
`define SRAWD_OFS_AMT      8'h04
`define SRAWD_OFS_CTRL     8'h08
`define SRAWD_OFS_EXEC     8'h0C
`define SRAWD_OFS_RESULT   8'h10
`define SRAWD_OFS_FLAGS    8'h14

// Shift-amount register fields (bits 27-31 and 26 counted from the MSB)
`define SRAWD_AMT_N_MSB    4
`define SRAWD_AMT_N_LSB    0
`define SRAWD_AMT_BIG      5

// Control register fields
`define SRAWD_CTRL_IMM_MSB 4
`define SRAWD_CTRL_IMM_LSB 0
`define SRAWD_CTRL_FORM    8
`define SRAWD_CTRL_REC     9

// Flags register fields
`define SRAWD_FLG_CARRY    0
`define SRAWD_FLG_CR_MSB   7
`define SRAWD_FLG_CR_LSB   4
`define SRAWD_FLG_SO       8

// Reset values
`define SRAWD_RST_WORD     32'h0000_0000
`define SRAWD_RST_CR       4'h0

`endif

// ---- srawd_pkg.sv ----
package srawd_pkg;

  // Operand source of the shift count
  typedef enum logic [0:0] {
    SRAWD_FORM_REG = 1'b0,
    SRAWD_FORM_IMM = 1'b1
  } srawd_form_t;

  // Whole state of the top module
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] src;
    logic [31:0] amt;
    logic [4:0]  imm;
    srawd_form_t form;
    logic        rec;
    logic [31:0] result;
    logic        carry;
    logic [3:0]  cr0;
    logic        so;
  } srawd_state_t;

endpackage : srawd_pkg

// ---- srawd_dp_if.sv ----
`timescale 1ns/1ps
interface srawd_dp_if #(
  parameter int W  = 32,
  parameter int SW = 5
);
  logic [W-1:0]  src;
  logic [SW-1:0] shamt;
  logic          zero_mask;
  logic [W-1:0]  result;
  logic          carry;
  logic          lt;
  logic          gt;
  logic          eq;

  modport core (
    input  src,
    input  shamt,
    input  zero_mask,
    output result,
    output carry,
    output lt,
    output gt,
    output eq
  );

  modport ctrl (
    output src,
    output shamt,
    output zero_mask,
    input  result,
    input  carry,
    input  lt,
    input  gt,
    input  eq
  );
endinterface : srawd_dp_if

// ---- srawd_core.sv ----
`timescale 1ns/1ps
module srawd_core #(
  parameter int W  = 32,
  parameter int SW = 5
) (
  srawd_dp_if.core dp
);

  logic [2*W-1:0] doubled;
  logic [W-1:0]   rot;
  logic [W-1:0]   mask;
  logic [W-1:0]   sign_word;

  // Rotate left by W minus N is a right rotate by N
  assign doubled   = {dp.src, dp.src} >> dp.shamt;
  assign rot       = doubled[W-1:0];
  // Sign bit replicated across the word
  assign sign_word = {W{dp.src[W-1]}};
  // N zeros then ones, or all zeros for oversize counts
  assign mask      = dp.zero_mask ? '0 : ({W{1'b1}} >> dp.shamt);

  // Merge and carry
  assign dp.result = (rot & mask) | (sign_word & ~mask);
  assign dp.carry  = (|(rot & ~mask)) & dp.src[W-1];

  // Signed compare against zero
  assign dp.lt = dp.result[W-1];
  assign dp.eq = ~|dp.result;
  assign dp.gt = ~dp.result[W-1] & |dp.result;

endmodule : srawd_core

// ---- srawd_top.sv ----
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "srawd_params.svh"
// Function
// - Register form: count from low five bits, rotate left by 32 minus count.
// - Sign word is the source sign bit copied into all 32 positions.
// - Register form, bit 26 clear: mask is N zeros then ones.
// - Register form, bit 26 set: mask all zeros, result equals sign word.
// - Result takes rotated bits under mask ones, sign bits elsewhere.
// - Carry: OR-reduce rotated AND inverted mask, then AND with source sign.
// - Immediate form: count from immediate field, never an all-zero mask.
// - Every form updates the carry flag, record bit or not.
// - Record bit set updates condition field 0; clear leaves it unchanged.
module srawd_top
  import srawd_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [ADDR_W-1:0] wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_wdat,
  output logic      [31:0]       wb_rdat,
  output logic                   wb_ack,
  output logic      [31:0]       dest_result,
  output logic                   carry_flag,
  output logic      [3:0]        cr0_bits
);

  // Elaboration checks
  if (DATA_W != `SRAWD_W) begin : g_bad_w
    $error("srawd_top supports only a 32-bit datapath");
  end
  if (ADDR_W < 5) begin : g_bad_a
    $error("srawd_top needs at least 5 address bits");
  end

  srawd_state_t s_q;
  srawd_state_t s_d;
  logic         req;
  logic         wr;
  logic         exec_fire;
  logic [7:0]   ofs;
  logic [31:0]  rd_word;

  srawd_dp_if #(.W(`SRAWD_W), .SW(`SRAWD_CNT_W)) dp ();

  srawd_core #(.W(`SRAWD_W), .SW(`SRAWD_CNT_W)) u_core (
    .dp (dp.core)
  );

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Register offset compare
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // Operand selection for the two forms
  assign dp.src       = s_q.src;
  assign dp.shamt     = (s_q.form == SRAWD_FORM_IMM) ? s_q.imm
                      : s_q.amt[`SRAWD_AMT_N_MSB:`SRAWD_AMT_N_LSB];
  assign dp.zero_mask = (s_q.form == SRAWD_FORM_REG) & s_q.amt[`SRAWD_AMT_BIG];

  // Bus request decode
  assign ofs       = 8'(wb_adr);
  assign req       = wb_cyc & wb_stb & ~s_q.ack;
  assign wr        = req & wb_we;
  assign exec_fire = ce & wr & hit(ofs, `SRAWD_OFS_EXEC);

  // Read mux
  always_comb begin
    rd_word = `SRAWD_RST_WORD;
    if (hit(ofs, `SRAWD_OFS_SRC)) begin
      rd_word = s_q.src;
    end else if (hit(ofs, `SRAWD_OFS_AMT)) begin
      rd_word = s_q.amt;
    end else if (hit(ofs, `SRAWD_OFS_CTRL)) begin
      rd_word[`SRAWD_CTRL_IMM_MSB:`SRAWD_CTRL_IMM_LSB] = s_q.imm;
      rd_word[`SRAWD_CTRL_FORM] = s_q.form;
      rd_word[`SRAWD_CTRL_REC]  = s_q.rec;
    end else if (hit(ofs, `SRAWD_OFS_RESULT)) begin
      rd_word = s_q.result;
    end else if (hit(ofs, `SRAWD_OFS_FLAGS)) begin
      rd_word[`SRAWD_FLG_CARRY] = s_q.carry;
      rd_word[`SRAWD_FLG_CR_MSB:`SRAWD_FLG_CR_LSB] = s_q.cr0;
      rd_word[`SRAWD_FLG_SO] = s_q.so;
    end
  end

  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.ack   = req;
    s_d.rdata = req ? rd_word : `SRAWD_RST_WORD;
    if (wr) begin
      if (hit(ofs, `SRAWD_OFS_SRC)) begin
        s_d.src = lane_merge(s_q.src, wb_wdat, wb_sel);
      end
      if (hit(ofs, `SRAWD_OFS_AMT)) begin
        s_d.amt = lane_merge(s_q.amt, wb_wdat, wb_sel);
      end
      if (hit(ofs, `SRAWD_OFS_CTRL) && wb_sel[0]) begin
        s_d.imm = wb_wdat[`SRAWD_CTRL_IMM_MSB:`SRAWD_CTRL_IMM_LSB];
      end
      if (hit(ofs, `SRAWD_OFS_CTRL) && wb_sel[1]) begin
        s_d.form = srawd_form_t'(wb_wdat[`SRAWD_CTRL_FORM]);
        s_d.rec  = wb_wdat[`SRAWD_CTRL_REC];
      end
      if (hit(ofs, `SRAWD_OFS_FLAGS) && wb_sel[1]) begin
        s_d.so = wb_wdat[`SRAWD_FLG_SO];
      end
    end
    // Execute: result and carry, and field 0 when the record bit is set, in one edge
    if (exec_fire) begin
      s_d.result = dp.result;
      s_d.carry  = dp.carry;
      if (s_q.rec) begin
        s_d.cr0 = {dp.lt, dp.gt, dp.eq, s_q.so};
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign wb_rdat     = s_q.rdata;
  assign wb_ack      = s_q.ack;
  assign dest_result = s_q.result;
  assign carry_flag  = s_q.carry;
  assign cr0_bits    = s_q.cr0;

  // Independent reference for checks
  logic [31:0] exp_sra;
  logic        exp_lost;
  logic        is_reg_big;
  assign is_reg_big = dp.zero_mask;
  assign exp_sra    = is_reg_big ? {32{s_q.src[31]}}
                    : 32'($signed(s_q.src) >>> dp.shamt);
  assign exp_lost   = is_reg_big ? (|s_q.src)
                    : (32'(exp_sra << dp.shamt) != s_q.src);

  property p_shift_reg;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && s_q.form == SRAWD_FORM_REG && !is_reg_big |=> dest_result == $past(exp_sra);
  endproperty
  a_shift_reg: assert property (p_shift_reg)
    else $error("register-form shift result wrong");

  property p_sign_word;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && is_reg_big |=> dest_result == {32{$past(s_q.src[31])}};
  endproperty
  a_sign_word: assert property (p_sign_word)
    else $error("oversize count did not give sign word");

  property p_shift_imm;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && s_q.form == SRAWD_FORM_IMM |=> dest_result == $past(exp_sra);
  endproperty
  a_shift_imm: assert property (p_shift_imm)
    else $error("immediate-form shift result wrong");

  property p_carry;
    @(posedge clk) disable iff (!rst_n)
      exec_fire |=> carry_flag == ($past(s_q.src[31]) & $past(exp_lost));
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong");

  property p_carry_norec;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && !s_q.rec && exp_lost && s_q.src[31] |=> carry_flag;
  endproperty
  a_carry_norec: assert property (p_carry_norec)
    else $error("carry not set without record");

  property p_cr_hold;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && !s_q.rec |=> $stable(cr0_bits);
  endproperty
  a_cr_hold: assert property (p_cr_hold)
    else $error("field 0 changed with record bit clear");

  property p_cr_set;
    @(posedge clk) disable iff (!rst_n)
      exec_fire && s_q.rec |=> cr0_bits == {dest_result[31], !dest_result[31] && dest_result != 0,
                                            dest_result == 0, $past(s_q.so)};
  endproperty
  a_cr_set: assert property (p_cr_set)
    else $error("field 0 does not match result");

  property p_one_cycle;
    @(posedge clk) disable iff (!rst_n)
      ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack || !ce;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("bus answer not in one cycle");

  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(dest_result) && $stable(wb_ack) && $stable(cr0_bits);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

endmodule : srawd_top

// ---- srawd_gpr_model.sv ----
`timescale 1ns/1ps
module srawd_gpr_model (
  input  wire logic [31:0] src,
  input  wire logic [31:0] amt,
  input  wire logic [9:0]  ctrl,
  input  wire logic        so,
  output logic      [31:0] res,
  output logic             carry,
  output logic      [3:0]  cr
);
  logic [4:0]  n;
  logic [63:0] dbl;
  logic [31:0] rot;
  logic [31:0] mask;

  // Operands as decode hands them over, reference merge
  always_comb begin
    n     = ctrl[8] ? ctrl[4:0] : amt[4:0];
    dbl   = {src, src} >> n;
    rot   = dbl[31:0];
    mask  = (!ctrl[8] && amt[5]) ? 32'h0000_0000 : (32'hFFFF_FFFF >> n);
    res   = (rot & mask) | ({32{src[31]}} & ~mask);
    carry = (|(rot & ~mask)) & src[31];
    cr    = {$signed(res) < 0, $signed(res) > 0, res == 32'h0000_0000, so};
  end
endmodule : srawd_gpr_model

// ---- test_shift_right_algebraic_word.sv ----
`timescale 1ns/1ps
module test_shift_right_algebraic_word;
  import srawd_pkg::*;
  logic        clk, rst_n, ce, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dest_result, rd, m_src, m_amt, m_res;
  logic        ack, carry_flag, m_so, m_carry;
  logic [3:0]  cr0_bits, m_cr, e_cr, lanes;
  logic [9:0]  m_ctl;
  int          failures, compares, cycles;
  // Cases: source, amount, control {rec,form,imm}, overflow, known result
  localparam logic [31:0] T_SRC [7] = '{32'h9000_3000, 32'hB004_3000, 32'h9000_3000,
    32'h7FFF_FFFF, 32'h8000_0001, 32'h0000_0005, 32'hFFFF_FFFF};
  localparam logic [31:0] T_AMT [7] = '{32'h0000_0024, 32'h0000_0004, 32'h0000_0024,
    32'h0000_001F, 32'h0000_0000, 32'h0000_0000, 32'h0000_0020};
  localparam logic [9:0]  T_CTL [7] = '{10'h000, 10'h200, 10'h104, 10'h200, 10'h31F,
    10'h200, 10'h200};
  localparam logic [31:0] T_EXP [7] = '{32'hFFFF_FFFF, 32'hFB00_4300, 32'hF900_0300,
    32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0005, 32'hFFFF_FFFF};
  localparam logic [6:0]  T_SO = 7'h08;

  srawd_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc(cyc), .wb_stb(stb),
    .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_wdat(wdat), .wb_rdat(rdat),
    .wb_ack(ack), .dest_result(dest_result), .carry_flag(carry_flag), .cr0_bits(cr0_bits));
  srawd_gpr_model PM (.src(m_src), .amt(m_amt), .ctrl(m_ctl), .so(m_so), .res(m_res),
    .carry(m_carry), .cr(m_cr));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic [3:0] e, input logic [3:0] g);
    chk_w(nm, {28'h0, e}, {28'h0, g});
  endtask : chk_b

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= lanes;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  initial begin
    {rst_n, cyc, stb, we, adr, sel, wdat, failures, compares, cycles} = '0;
    ce = 1'b1;
    lanes = 4'hF;
    e_cr = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_w("reset result", 32'h0000_0000, dest_result);
    chk_b("reset cr0", 4'h0, cr0_bits);
    for (int i = 0; i < 7; i++) begin
      m_src = T_SRC[i]; m_amt = T_AMT[i]; m_ctl = T_CTL[i]; m_so = T_SO[i];
      wb(1'b1, 8'h00, m_src);
      wb(1'b1, 8'h04, m_amt);
      wb(1'b1, 8'h08, {22'h0, m_ctl});
      wb(1'b1, 8'h14, {23'h0, m_so, 8'h00});
      wb(1'b1, 8'h0C, 32'h0000_0001);
      if (m_ctl[9]) e_cr = m_cr;
      chk_w("known", T_EXP[i], dest_result);
      chk_w("result", m_res, dest_result);
      chk_b("carry", {3'h0, m_carry}, {3'h0, carry_flag});
      chk_b("cr0", e_cr, cr0_bits);
      wb(1'b0, 8'h10, 32'h0);
      chk_w("result reg", m_res, rd);
      wb(1'b0, 8'h14, 32'h0);
      chk_w("flags", {23'h0, m_so, e_cr, 3'h0, m_carry}, rd);
    end
    // Readback of the operands of the last case
    wb(1'b0, 8'h00, 32'h0);
    chk_w("src reg", T_SRC[6], rd);
    wb(1'b0, 8'h04, 32'h0);
    chk_w("amt reg", T_AMT[6], rd);
    wb(1'b0, 8'h08, 32'h0);
    chk_w("ctrl reg", {22'h0, T_CTL[6]}, rd);
    // Write through the two low byte lanes only
    lanes = 4'h3;
    wb(1'b1, 8'h00, 32'h1234_5678);
    lanes = 4'hF;
    wb(1'b0, 8'h00, 32'h0);
    chk_w("lane merge", 32'hFFFF_5678, rd);
    // Clock enable low: a pending write must wait and nothing moves
    @(posedge clk);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= 8'h00;
    wdat <= 32'h0000_0000;
    repeat (4) @(posedge clk);
    chk_b("frozen ack", 4'h0, {3'h0, ack});
    chk_w("frozen result", T_EXP[6], dest_result);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    ce <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    chk_w("frozen src", 32'hFFFF_5678, rd);
    // Reset again in mid-run clears the outputs
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_w("rerun result", 32'h0000_0000, dest_result);
    chk_b("rerun carry", 4'h0, {3'h0, carry_flag});
    chk_b("rerun cr0", 4'h0, cr0_bits);
    wb(1'b1, 8'h3C, 32'hA5A5_A5A5);
    wb(1'b0, 8'h3C, 32'h0);
    chk_w("unmapped", 32'h0000_0000, rd);
    wb(1'b0, 8'h0C, 32'h0);
    chk_w("exec read", 32'h0000_0000, rd);
    conclude();
  end
endmodule : test_shift_right_algebraic_word
